/* hdl/drive_trip_protection_logic.sv */
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "trip_cfg.svh"
module drive_trip_protection_logic #(
   parameter int NUM_DI  = 8,
   parameter int NUM_EXT = 4
) (
   input  wire logic              CLOCK_I,
   input  wire logic              RST_B_I,
   input  wire logic              CE_I,
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [7:0]        WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic      [31:0]       WB_DAT_O,
   output logic                   WB_ACK_O,
   input  wire logic [NUM_DI-1:0] DI_I,
   input  wire trip_pkg::meas_t   MEAS_I,
   input  wire trip_pkg::drv_mode_t MODE_I,
   output logic                   CUTOFF_O,
   output logic      [2:0]        TRIP_CODE_O,
   output logic      [2:0]        PHASE_CODE_O,
   output logic                   IRQ_O
);
   // Decoder and register layout are built for eight inputs and four sources
   if (NUM_DI != 8 || NUM_EXT != 4) begin : g_bad_size
      $error("only eight inputs and four trip sources are supported");
   end

   typedef struct packed {
      logic                   ack;
      logic [31:0]            rdat;
      logic                   in_en;
      logic                   out_en;
      logic [31:0]            func;
      logic [NUM_DI-1:0]      pol;
      logic [NUM_EXT-1:0]     ext_mode;
      logic [6:0]             band;
      logic                   rst_pulse;
      logic                   in_loss;
      trip_pkg::drv_state_t   st;
      logic                   cutoff;
      logic [2:0]             code;
      logic [3:0]             irq_stat;
      logic [3:0]             irq_en;
      logic                   irq;
   } top_st_t;

   top_st_t s_q, s_d;
   logic [1:0]         rsync_q;
   logic               rst_b;
   logic [NUM_DI-1:0]  di_act;
   logic [NUM_EXT-1:0] ext_src;
   logic [NUM_EXT-1:0] ext_trip;
   logic               out_active;
   logic               out_fault;
   logic [2:0]         out_code;
   logic               wr_stb;
   logic               rd_stb;
   logic [31:0]        wmask;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rsync_q <= 2'h0;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end
   assign rst_b = rsync_q[1];

   // Byte lane mask from sel
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   // Function code of one input, four bits per input
   function automatic logic [3:0] func_of(input logic [31:0] f, input int idx);
      func_of = f[idx*4 +: 4];
   endfunction : func_of

   // Contact polarity per input
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DI; gi++) begin : g_pol
         assign di_act[gi] = DI_I[gi] ^ s_q.pol[gi];
      end
   endgenerate

   // Any input with code 5+n drives source n
   always_comb begin
      ext_src = '0;
      for (int i = 0; i < NUM_DI; i++) begin
         for (int n = 0; n < NUM_EXT; n++) begin
            if (func_of(s_q.func, i) == `FUNC_EXT1 + 4'(n) && di_act[i]) begin
               ext_src[n] = 1'b1;
            end
         end
      end
   end

   // One channel per source, each with its own mode bit
   generate
      for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
         ext_trip_chan u_chan (
            .clk_i   (CLOCK_I),
            .rst_b_i (rst_b),
            .ce_i    (CE_I),
            .src_i   (ext_src[gi]),
            .mode_i  (s_q.ext_mode[gi]),
            .clear_i (s_q.rst_pulse),
            .trip_o  (ext_trip[gi])
         );
      end
   endgenerate

   // Output check only while running and not in a special state
   assign out_active = s_q.out_en && (s_q.st == trip_pkg::ST_RUN)
                       && !MODE_I.stopped && !MODE_I.exciting
                       && !MODE_I.flux_build && !MODE_I.searching && !MODE_I.tuning;

   out_phase_chk u_out (
      .clk_i    (CLOCK_I),
      .rst_b_i  (rst_b),
      .ce_i     (CE_I),
      .active_i (out_active),
      .open_i   ({MEAS_I.ph_u_open, MEAS_I.ph_v_open, MEAS_I.ph_w_open}),
      .fault_o  (out_fault),
      .code_o   (out_code)
   );

   // Write lands at the edge where the master samples ack high
   assign wr_stb = WB_CYC_I && WB_STB_I && WB_WE_I && s_q.ack;
   assign rd_stb = WB_CYC_I && WB_STB_I && !WB_WE_I && !s_q.ack;
   assign wmask  = lane_mask(WB_SEL_I);

   // Register access, protection state and interrupt
   always_comb begin
      logic [3:0] ev;
      ev = '0;
      s_d = s_q;
      s_d.ack = WB_CYC_I && WB_STB_I && !s_q.ack;
      s_d.rst_pulse = 1'b0;
      // Input loss: enabled, load at least half, deviation beyond band
      s_d.in_loss = s_q.in_en && (MEAS_I.load_pct >= `LOAD_HALF_PCT)
                    && (MEAS_I.in_dev_volt > s_q.band);
      if (wr_stb) begin
         unique case (WB_ADR_I)
            `OFS_CTRL: begin
               if (WB_SEL_I[0]) begin
                  s_d.in_en     = WB_DAT_I[`BIT_IN_EN];
                  s_d.out_en    = WB_DAT_I[`BIT_OUT_EN];
                  s_d.rst_pulse = WB_DAT_I[`BIT_RESET];
                  s_d.ext_mode  = WB_DAT_I[7:4];
               end
            end
            `OFS_FUNC_LO: s_d.func = (s_q.func & ~wmask) | (WB_DAT_I & wmask);
            `OFS_POL: if (WB_SEL_I[0]) s_d.pol = WB_DAT_I[7:0];
            `OFS_BAND: begin
               // Out-of-range band writes are ignored
               if (WB_SEL_I[0] && WB_DAT_I[6:0] >= `BAND_MIN && WB_DAT_I[6:0] <= `BAND_MAX) begin
                  s_d.band = WB_DAT_I[6:0];
               end
            end
            `OFS_IRQ_EN: if (WB_SEL_I[0]) s_d.irq_en = WB_DAT_I[3:0];
            `OFS_IRQ_CLR: if (WB_SEL_I[0]) s_d.irq_stat = s_q.irq_stat & ~WB_DAT_I[3:0];
            default: ;
         endcase
      end
      // Read mux; unmapped reads as zero
      if (rd_stb) begin
         unique case (WB_ADR_I)
            `OFS_CTRL:     s_d.rdat = {24'h0, s_q.ext_mode, 2'h0, s_q.out_en, s_q.in_en};
            `OFS_FUNC_LO:  s_d.rdat = s_q.func;
            `OFS_POL:      s_d.rdat = {24'h0, s_q.pol};
            `OFS_BAND:     s_d.rdat = {25'h0, s_q.band};
            `OFS_STAT:     s_d.rdat = {19'h0, ext_trip, 1'b0, s_q.code, s_q.in_loss, s_q.cutoff, s_q.st};
            `OFS_IRQ_STAT: s_d.rdat = {28'h0, s_q.irq_stat};
            `OFS_IRQ_EN:   s_d.rdat = {28'h0, s_q.irq_en};
            default:       s_d.rdat = 32'h0;
         endcase
      end
      // Drive state: trip on any fault, reset returns to idle
      unique case (s_q.st)
         trip_pkg::ST_IDLE: if (!MODE_I.stopped) s_d.st = trip_pkg::ST_RUN;
         trip_pkg::ST_RUN: if (MODE_I.stopped) s_d.st = trip_pkg::ST_IDLE;
         trip_pkg::ST_TRIP: ;
         default: s_d.st = trip_pkg::ST_IDLE;
      endcase
      if (out_fault) begin
         s_d.st = trip_pkg::ST_TRIP;
         s_d.code = out_code;
         ev[0] = 1'b1;
      end else if (s_q.in_loss) begin
         s_d.st = trip_pkg::ST_TRIP;
         s_d.code = `CODE_INPUT;
         ev[1] = 1'b1;
      end else if (|ext_trip) begin
         s_d.st = trip_pkg::ST_TRIP;
         if (s_q.st != trip_pkg::ST_TRIP) s_d.code = `CODE_EXT;
         ev[2] = 1'b1;
      end else if (s_q.st == trip_pkg::ST_TRIP && s_q.rst_pulse) begin
         s_d.st = trip_pkg::ST_IDLE;
         s_d.code = `CODE_NONE;
         ev[3] = 1'b1;
      end else if (s_q.st == trip_pkg::ST_TRIP && s_q.code == `CODE_EXT) begin
         // Level trips release without reset
         s_d.st = trip_pkg::ST_IDLE;
         s_d.code = `CODE_NONE;
         ev[3] = 1'b1;
      end
      s_d.cutoff = (s_d.st == trip_pkg::ST_TRIP);
      // Set wins over clear
      s_d.irq_stat = s_d.irq_stat | ev;
      s_d.irq = |(s_d.irq_stat & s_d.irq_en);
   end

   // State register; mode and polarity default to zero
   always_ff @(posedge CLOCK_I or negedge rst_b) begin
      if (!rst_b) begin
         s_q       <= '0;
         s_q.band  <= `BAND_RESET;
         s_q.func  <= 32'h0;
         s_q.st    <= trip_pkg::ST_IDLE;
      end else if (CE_I) begin
         s_q <= s_d;
      end
   end

   assign WB_ACK_O     = s_q.ack;
   assign WB_DAT_O     = s_q.rdat;
   assign CUTOFF_O     = s_q.cutoff;
   assign TRIP_CODE_O  = s_q.code;
   assign PHASE_CODE_O = out_code;
   assign IRQ_O        = s_q.irq;

   // Trip entry, blocking and release checks
   chk_ext_trip_cut: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && (|ext_trip) |=> CUTOFF_O)
      else $error("external trip did not cut off");
   chk_out_fault_cut: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && out_fault |=> CUTOFF_O && TRIP_CODE_O == $past(out_code))
      else $error("phase fault not tripped");
   chk_stop_blocks: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && MODE_I.stopped |=> !out_fault)
      else $error("check ran while stopped");
   chk_tuning_blocks: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && (MODE_I.tuning || MODE_I.searching || CUTOFF_O) |=> !out_fault)
      else $error("check ran in blocked state");
   chk_light_load: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && MEAS_I.load_pct < `LOAD_HALF_PCT |=> !s_q.in_loss)
      else $error("input check at light load");
   chk_band_range: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      s_q.band >= `BAND_MIN && s_q.band <= `BAND_MAX)
      else $error("band out of range");
   chk_enable_gate: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && !s_q.in_en |=> !s_q.in_loss)
      else $error("disabled input check tripped");
   chk_out_disabled: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && !s_q.out_en |=> !out_fault)
      else $error("disabled output check tripped");
   chk_in_loss_trip: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && s_q.in_loss && !out_fault |=> CUTOFF_O && TRIP_CODE_O == `CODE_INPUT)
      else $error("input loss not tripped");
   // A level trip must not need the reset pulse to release
   chk_level_release: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && s_q.st == trip_pkg::ST_TRIP && s_q.code == `CODE_EXT && !(|ext_trip)
      && !out_fault && !s_q.in_loss |=> !CUTOFF_O)
      else $error("level trip not released");
   chk_reset_release: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && s_q.rst_pulse && !(|ext_trip) && !out_fault && !s_q.in_loss |=> !CUTOFF_O)
      else $error("trip reset ignored");
   chk_ack_drop: assert property (@(posedge CLOCK_I) disable iff (!rst_b)
      CE_I && WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held two cycles");
endmodule : drive_trip_protection_logic
`default_nettype wire

/* hdl/ext_trip_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_trip_chan (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic ce_i,
   input  wire logic src_i,
   input  wire logic mode_i,
   input  wire logic clear_i,
   output logic      trip_o
);
   typedef struct packed { logic trip; } chan_st_t;
   chan_st_t s_q, s_d;
   // Latch holds until clear; level follows input; source wins over clear
   always_comb begin
      s_d = s_q;
      if (src_i) begin
         s_d.trip = 1'b1;
      end else if (mode_i || clear_i) begin
         s_d.trip = 1'b0;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
   assign trip_o = s_q.trip;
   chk_level_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && !src_i && mode_i |=> !trip_o) else $error("level trip stuck");
   chk_latch_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && trip_o && !mode_i && !clear_i |=> trip_o) else $error("latch dropped");
endmodule : ext_trip_chan
`default_nettype wire

/* hdl/out_phase_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trip_cfg.svh"
module out_phase_chk (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       ce_i,
   input  wire logic       active_i,
   input  wire logic [2:0] open_i,
   output logic            fault_o,
   output logic [2:0]      code_o
);
   typedef struct packed { logic fault; logic [2:0] code; } ph_st_t;
   ph_st_t s_q, s_d;
   // Phase code for one open phase, no-motor for two or more
   always_comb begin
      s_d = s_q;
      s_d.fault = active_i && (|open_i);
      // Code holds while blocked so the last finding stays readable
      if (active_i) begin
         unique case (open_i)
            3'b100:  s_d.code = `CODE_U;
            3'b010:  s_d.code = `CODE_V;
            3'b001:  s_d.code = `CODE_W;
            3'b000:  s_d.code = `CODE_NONE;
            default: s_d.code = `CODE_NOMOTOR;
         endcase
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
   assign fault_o = s_q.fault;
   assign code_o  = s_q.code;
   chk_multi_phase: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && active_i && $countones(open_i) >= 2 |=> code_o == `CODE_NOMOTOR)
      else $error("no-motor code missing");
   chk_single_phase: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && active_i && $onehot(open_i) |=> code_o inside {`CODE_U, `CODE_V, `CODE_W})
      else $error("single phase code missing");
endmodule : out_phase_chk
`default_nettype wire

/* hdl/trip_cfg.svh */
// Function
// - Function codes 5-8 map inputs to trips 1-4
// - Polarity 0 normally open, 1 normally closed
// - Latch mode holds trip until reset
// - Level mode clears trip when input drops
// - Each external trip has its own mode
// - Input loss band 1-100 V, default 20
// - Input loss checked only at load >=50%
// - Open output phase cuts drive and trips
// - No output check while tripped, exciting, searching, tuning
// - No output check while drive is stopped
// - Single open phase reports its phase code
// - Two or more open phases report no-motor
`ifndef TRIP_CFG_SVH
`define TRIP_CFG_SVH
`define OFS_CTRL      8'h00
`define OFS_FUNC_LO   8'h04
`define OFS_FUNC_HI   8'h08
`define OFS_POL       8'h0C
`define OFS_BAND      8'h10
`define OFS_STAT      8'h14
`define OFS_IRQ_STAT  8'h18
`define OFS_IRQ_CLR   8'h1C
`define OFS_IRQ_EN    8'h20
`define OFS_ID        8'h24
`define BIT_IN_EN     0
`define BIT_OUT_EN    1
`define BIT_RESET     2
`define FUNC_EXT1     4'h5
`define BAND_RESET    7'h14
`define BAND_MIN      7'h01
`define BAND_MAX      7'h64
`define LOAD_HALF_PCT 8'h32
`define CODE_NONE     3'h0
`define CODE_U        3'h1
`define CODE_V        3'h2
`define CODE_W        3'h3
`define CODE_NOMOTOR  3'h4
`define CODE_INPUT    3'h5
`define CODE_EXT      3'h6
`endif

/* hdl/trip_pkg.sv */
package trip_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_TRIP = 3'b100
   } drv_state_t;
   typedef struct packed {
      logic stopped;
      logic exciting;
      logic flux_build;
      logic searching;
      logic tuning;
   } drv_mode_t;
   typedef struct packed {
      logic       ph_u_open;
      logic       ph_v_open;
      logic       ph_w_open;
      logic [6:0] in_dev_volt;
      logic [7:0] load_pct;
   } meas_t;
endpackage : trip_pkg

/* verif/field_model.sv */
`timescale 1ns/1ps
`default_nettype none
module field_model (
   input  wire logic [7:0] closed_i,
   input  wire logic [2:0] open_i,
   input  wire logic [6:0] volt_i,
   input  wire logic [7:0] load_i,
   output logic      [7:0] di_o,
   output var trip_pkg::meas_t meas_o
);
   // A closed contact reads high at the terminal
   assign di_o = closed_i;
   // Phase order U, V, W as the power stage reports it
   assign meas_o = {open_i, volt_i, load_i};
endmodule : field_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, closed = 8'h00, load = 8'h00, di;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_w = 32'h0, dat_r, rq, ctrl;
   logic [2:0] open_ph = 3'h0, code, pcode;
   logic [6:0] volt = 7'h00;
   logic ack, cut, irq;
   logic ce = 1'b1;
   trip_pkg::drv_mode_t mode = 5'h10;
   trip_pkg::meas_t meas;
   int failures = 0, n_compared = 0;

   // 40 MHz system clock
   always #12.5 clk = ~clk;

   field_model u_field_model (.closed_i(closed), .open_i(open_ph), .volt_i(volt), .load_i(load),
                              .di_o(di), .meas_o(meas));
   drive_trip_protection_logic u_drive_trip_protection_logic (
      .CLOCK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
      .DI_I(di), .MEAS_I(meas), .MODE_I(mode), .CUTOFF_O(cut), .TRIP_CODE_O(code),
      .PHASE_CODE_O(pcode), .IRQ_O(irq));

   task test_done;
      if (failures == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %0h seen %0h", nm, e, s);
      end
   endtask : check

   // Classic cycle; held until ack is sampled, bounded wait
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, dat_w, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         test_done;
      end
      rq = dat_r;
      {cyc, stb, we} <= 3'h0;
   endtask : wb

   task automatic settle;
      repeat (4) @(posedge clk);
   endtask : settle

   task automatic oc(input logic c, input logic [2:0] k);
      check("cutoff", 32'(cut), 32'(c));
      check("trip code", 32'(code), 32'(k));
   endtask : oc

   // Trip reset pulse keeps the shadowed enables and modes
   task automatic clr;
      wb(1'b1, 8'h00, ctrl | 32'h4);
      settle;
   endtask : clr

   task automatic t_regs;
      wb(1'b0, 8'h10, 32'h0); check("band", rq, 32'h14);
      wb(1'b0, 8'h00, 32'h0); check("ctrl", rq, 32'h0);
      wb(1'b0, 8'h0C, 32'h0); check("polarity", rq, 32'h0);
      wb(1'b0, 8'hFC, 32'h0); check("unmapped", rq, 32'h0);
      wb(1'b1, 8'h10, 32'h0);
      wb(1'b1, 8'h10, 32'h65);
      wb(1'b0, 8'h10, 32'h0); check("band range", rq, 32'h14);
      wb(1'b1, 8'h10, 32'h64);
      wb(1'b0, 8'h10, 32'h0); check("band max", rq, 32'h64);
      wb(1'b1, 8'h10, 32'h14);
   endtask : t_regs

   // Both checks still off after reset
   task automatic t_disabled;
      {mode, open_ph, volt, load} <= {5'h00, 3'h4, 7'h50, 8'h64};
      settle;
      oc(1'b0, 3'h0);
      {open_ph, volt, load} <= {3'h0, 7'h00, 8'h00};
   endtask : t_disabled

   task automatic t_input_loss;
      ctrl = 32'h1;
      wb(1'b1, 8'h00, ctrl);
      {volt, load} <= {7'h14, 8'h32};
      settle;
      oc(1'b0, 3'h0);
      {volt, load} <= {7'h1E, 8'h31};
      settle;
      oc(1'b0, 3'h0);
      load <= 8'h32;
      settle;
      oc(1'b1, 3'h5);
      {volt, load} <= {7'h00, 8'h00};
      clr;
      oc(1'b0, 3'h0);
   endtask : t_input_loss

   task automatic t_out_phase;
      ctrl = 32'h2;
      wb(1'b1, 8'h00, ctrl);
      {mode, open_ph} <= {5'h10, 3'h4};
      settle;
      oc(1'b0, 3'h0);
      for (int i = 0; i < 4; i++) begin
         mode <= 5'h08 >> i;
         settle;
         oc(1'b0, 3'h0);
      end
      for (int p = 0; p < 3; p++) begin
         {mode, open_ph} <= {5'h00, 3'(3'h4 >> p)};
         settle;
         oc(1'b1, 3'(p + 1));
         check("phase code", 32'(pcode), 32'(p + 1));
         if (p == 0) begin
            open_ph <= 3'h3;
            settle;
            oc(1'b1, 3'h1);
         end
         open_ph <= 3'h0;
         clr;
         oc(1'b0, 3'h0);
      end
      open_ph <= 3'h3;
      settle;
      oc(1'b1, 3'h4);
      {mode, open_ph} <= {5'h10, 3'h0};
      clr;
   endtask : t_out_phase

   // Inputs 0-3 carry trip functions 5-8; input 4 stays unassigned
   task automatic t_ext;
      ctrl = 32'h0;
      wb(1'b1, 8'h00, ctrl);
      wb(1'b1, 8'h04, 32'h8765);
      for (int k = 0; k < 4; k++) begin
         closed <= 8'(1 << k);
         settle;
         oc(1'b1, 3'h6);
         closed <= 8'h00;
         settle;
         oc(1'b1, 3'h6);
         clr;
         oc(1'b0, 3'h0);
      end
      ctrl = 32'h20;
      wb(1'b1, 8'h00, ctrl);
      wb(1'b1, 8'h0C, 32'h2);
      closed <= 8'h12;
      settle;
      oc(1'b0, 3'h0);
      closed <= 8'h00;
      settle;
      oc(1'b1, 3'h6);
      closed <= 8'h02;
      settle;
      oc(1'b0, 3'h0);
      closed <= 8'h03;
      settle;
      closed <= 8'h02;
      settle;
      oc(1'b1, 3'h6);
      clr;
   endtask : t_ext

   // Latched external trip status stays set until cleared
   task automatic t_irq;
      wb(1'b1, 8'h20, 32'h4);
      closed <= 8'h03;
      settle;
      check("irq", 32'(irq), 32'h1);
      wb(1'b0, 8'h18, 32'h0); check("irq status", rq & 32'h4, 32'h4);
      wb(1'b1, 8'h20, 32'h0);
      settle;
      check("irq masked", 32'(irq), 32'h0);
      closed <= 8'h02;
      clr;
      wb(1'b1, 8'h1C, 32'hF);
      wb(1'b0, 8'h18, 32'h0); check("irq cleared", rq, 32'h0);
      wb(1'b1, 8'h20, 32'h4);
      settle;
      check("irq idle", 32'(irq), 32'h0);
   endtask : t_irq

   // Enable low freezes the trip; it follows once enable returns
   task automatic t_freeze;
      ce <= 1'b0;
      closed <= 8'h03;
      settle;
      oc(1'b0, 3'h0);
      ce <= 1'b1;
      settle;
      oc(1'b1, 3'h6);
      check("irq", 32'(irq), 32'h1);
      closed <= 8'h02;
      clr;
      oc(1'b0, 3'h0);
   endtask : t_freeze

   // Mid-run reset returns modes, polarities and enables to zero
   task automatic t_rst;
      rst_b <= 1'b0;
      settle;
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      oc(1'b0, 3'h0);
      wb(1'b0, 8'h00, 32'h0); check("ctrl after reset", rq, 32'h0);
      wb(1'b0, 8'h0C, 32'h0); check("polarity after reset", rq, 32'h0);
      check("irq after reset", 32'(irq), 32'h0);
   endtask : t_rst

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs;
      t_disabled;
      t_input_loss;
      t_out_phase;
      t_ext;
      t_irq;
      t_freeze;
      t_rst;
      test_done;
   end
endmodule : testbench
`default_nettype wire
